// ===== shared/load_group_pkg.sv
// Constants for the byte load group decoder
// ---------------------------------------------------------------
// What this block does
// [RULE1] Opcode 48H copies register B into C
// [RULE2] Fetch opcode, decode, then perform transfer
// [RULE3] Opcode 72H stores D at pointer pair address
// [RULE4] Indexed loads are three bytes, displacement third
// [RULE5] Direct accumulator loads take two address bytes
// [RULE6] Address low byte first, high byte second
// [RULE7] Immediate register loads are two bytes long
// [RULE8] Instructions are one to four bytes long
// [RULE9] Displacement is signed two's complement
// [RULE10] Index register stays unchanged by addressing
// [RULE11] Displacement precedes immediate; indexed store four bytes
// ---------------------------------------------------------------
package load_group_pkg;
  localparam logic [7:0] PFX_FIRST_INDEX  = 8'hDD;
  localparam logic [7:0] PFX_SECOND_INDEX = 8'hFD;
  localparam logic [7:0] OP_MOVE_B_TO_C   = 8'h48;
  localparam logic [7:0] OP_HALT          = 8'h76;
  localparam logic [7:0] OP_STORE_D_PTR   = 8'h72;
  localparam logic [7:0] OP_STORE_IMM_IDX = 8'h36;
  localparam logic [7:0] OP_LOAD_A_DIRECT = 8'h3A;
  localparam logic [7:0] OP_STORE_A_DIRECT = 8'h32;
  localparam logic [2:0] REG_B   = 3'h0;
  localparam logic [2:0] REG_C   = 3'h1;
  localparam logic [2:0] REG_D   = 3'h2;
  localparam logic [2:0] REG_E   = 3'h3;
  localparam logic [2:0] REG_H   = 3'h4;
  localparam logic [2:0] REG_L   = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A   = 3'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  typedef enum logic [6:0] {
    ST_FETCH = 7'h01,
    ST_PFX   = 7'h02,
    ST_DISP  = 7'h04,
    ST_IMM   = 7'h08,
    ST_ADLO  = 7'h10,
    ST_ADHI  = 7'h20,
    ST_MEM   = 7'h40
  } state_t;
endpackage

// ===== hw/byte_load_group_decoder.sv
// Byte load group decoder and executor
`timescale 1ns/100ps
module byte_load_group_decoder #(
  parameter int unsigned REG_COUNT = 8
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Memory bus
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ready,
  // Status
  output logic             opcode_fetch_cycle,
  output logic             instr_done,
  output logic [2:0]       instr_len,
  // Register view
  output logic [63:0]      reg_view,
  output logic [15:0]      first_index_register,
  output logic [15:0]      second_index_register,
  output logic [15:0]      pc
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  load_group_pkg::state_t state;
  logic [7:0]  regs [REG_COUNT];
  logic [7:0]  opcode;
  logic [1:0]  idx_sel;
  logic [7:0]  disp;
  logic [7:0]  imm;
  logic [15:0] ea;
  logic [2:0]  len;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (REG_COUNT != 8) begin : g_bad_count
    $error("register count must be eight");
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  function automatic logic is_prefix(input logic [7:0] b);
    is_prefix = b == load_group_pkg::PFX_FIRST_INDEX ||
                b == load_group_pkg::PFX_SECOND_INDEX;
  endfunction

  function automatic logic [7:0] wsel(input logic [7:0] op,
                                      input logic [7:0] im,
                                      input logic [7:0] sv);
    wsel = op[7:6] == 2'b00 ? im : sv;
  endfunction

  wire logic [2:0] dst = opcode[5:3];
  wire logic [2:0] src = opcode[2:0];
  wire logic is_halt = opcode == load_group_pkg::OP_HALT;
  wire logic is_move = opcode[7:6] == 2'b01 && !is_halt;
  wire logic is_imm  = opcode[7:6] == 2'b00 && opcode[2:0] == 3'h6;
  wire logic is_dir  = opcode == load_group_pkg::OP_LOAD_A_DIRECT ||
                       opcode == load_group_pkg::OP_STORE_A_DIRECT;
  wire logic uses_mem = (is_move && (dst == load_group_pkg::REG_MEM ||
                         src == load_group_pkg::REG_MEM)) ||
                        (is_imm && dst == load_group_pkg::REG_MEM) ||
                        is_dir;
  wire logic mem_is_wr = (is_move && dst == load_group_pkg::REG_MEM) ||
                         is_imm ||
                         opcode == load_group_pkg::OP_STORE_A_DIRECT;
  wire logic idx_mem = idx_sel != 2'b00 && (is_move || is_imm) && uses_mem;

  // ---------------------------------------------------------------
  // Index addressing
  // ---------------------------------------------------------------
  wire logic [15:0] idx_base = idx_sel[0] ? first_index_register
                                          : second_index_register;
  // Signed displacement, index itself left untouched
  wire logic [15:0] idx_ea = idx_base + {{8{disp[7]}}, disp}; // [RULE9] [RULE10]
  wire logic [15:0] ptr_pair = {regs[load_group_pkg::REG_H],
                                regs[load_group_pkg::REG_L]};

  // ---------------------------------------------------------------
  // Operand selection
  // ---------------------------------------------------------------
  wire logic [7:0] src_val = is_imm ? imm : regs[src];
  wire logic [2:0] load_dst = is_dir ? load_group_pkg::REG_A : dst;
  wire logic [7:0] store_val = is_dir ? regs[load_group_pkg::REG_A]
                                      : wsel(opcode, imm, regs[src]);
  wire logic pfx_byte = is_prefix(mem_rdata);
  wire logic [1:0] pfx_sel = {1'b1, ~mem_rdata[5]};
  wire logic byte_in = mem_ready;

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign opcode_fetch_cycle = state == load_group_pkg::ST_FETCH ||
                              state == load_group_pkg::ST_PFX; // [RULE2]
  assign mem_rd = state != load_group_pkg::ST_MEM || !mem_is_wr;
  assign mem_wr = state == load_group_pkg::ST_MEM && mem_is_wr;
  assign mem_addr = state == load_group_pkg::ST_MEM ? ea : pc;
  assign mem_wdata = store_val;

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  assign instr_len = len;

  // ---------------------------------------------------------------
  // Register view
  // ---------------------------------------------------------------
  genvar g;
  for (g = 0; g < REG_COUNT; g++) begin : g_view
    assign reg_view[g*8 +: 8] = regs[g];
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= load_group_pkg::ST_FETCH;
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= load_group_pkg::RESET_BYTE;
      end
      opcode <= load_group_pkg::RESET_BYTE;
      idx_sel <= 2'b00;
      disp <= load_group_pkg::RESET_BYTE;
      imm <= load_group_pkg::RESET_BYTE;
      ea <= load_group_pkg::RESET_WORD;
      len <= 3'h0;
      pc <= load_group_pkg::RESET_WORD;
      first_index_register <= load_group_pkg::RESET_WORD;
      second_index_register <= load_group_pkg::RESET_WORD;
      instr_done <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      if (byte_in) begin
        unique case (state)
          load_group_pkg::ST_FETCH: begin
            pc <= pc + 16'h0001;
            len <= 3'h1;
            if (pfx_byte) begin
              idx_sel <= pfx_sel;
              state <= load_group_pkg::ST_PFX;
            end else begin
              idx_sel <= 2'b00;
              opcode <= mem_rdata;
              state <= load_group_pkg::ST_DISP;
            end
          end
          load_group_pkg::ST_PFX: begin
            pc <= pc + 16'h0001;
            len <= 3'h2; // [RULE8]
            opcode <= mem_rdata;
            state <= load_group_pkg::ST_DISP;
          end
          load_group_pkg::ST_DISP: begin
            // Decode point; displacement directly after opcode
            if (idx_mem) begin
              disp <= mem_rdata; // [RULE4] [RULE11]
              pc <= pc + 16'h0001;
              len <= len + 3'h1;
              state <= is_imm ? load_group_pkg::ST_IMM
                              : load_group_pkg::ST_ADLO;
            end else if (is_imm) begin
              imm <= mem_rdata; // [RULE7]
              pc <= pc + 16'h0001;
              len <= len + 3'h1;
              ea <= ptr_pair;
              state <= dst == load_group_pkg::REG_MEM ?
                       load_group_pkg::ST_MEM : load_group_pkg::ST_FETCH;
              if (dst != load_group_pkg::REG_MEM) begin
                regs[dst] <= mem_rdata; // [RULE7]
                instr_done <= 1'b1;
              end
            end else if (is_dir) begin
              ea[7:0] <= mem_rdata; // [RULE5] [RULE6]
              pc <= pc + 16'h0001;
              len <= len + 3'h1;
              state <= load_group_pkg::ST_ADHI;
            end else if (is_move && uses_mem) begin
              ea <= ptr_pair; // [RULE3]
              state <= load_group_pkg::ST_MEM;
            end else begin
              if (is_move) begin
                regs[dst] <= src_val; // [RULE1]
              end
              instr_done <= 1'b1;
              state <= load_group_pkg::ST_FETCH;
            end
          end
          load_group_pkg::ST_IMM: begin
            imm <= mem_rdata; // [RULE11]
            pc <= pc + 16'h0001;
            len <= len + 3'h1;
            state <= load_group_pkg::ST_ADLO;
          end
          load_group_pkg::ST_ADLO: begin
            ea <= idx_ea; // [RULE9]
            state <= load_group_pkg::ST_MEM;
          end
          load_group_pkg::ST_ADHI: begin
            ea[15:8] <= mem_rdata; // [RULE6]
            pc <= pc + 16'h0001;
            len <= len + 3'h1;
            state <= load_group_pkg::ST_MEM;
          end
          load_group_pkg::ST_MEM: begin
            if (!mem_is_wr) begin
              regs[load_dst] <= mem_rdata;
            end
            instr_done <= 1'b1;
            state <= load_group_pkg::ST_FETCH;
          end
        endcase
      end
    end
  end
endmodule

// ===== bench/program_memory.sv
// Program memory model on the far side of the decoder
`timescale 1ns/100ps
module program_memory (
  // Clock, reset, stall select and bus from the decoder
  input wire logic mclk, rstn, slow, mem_rd, mem_wr,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  // Answer
  output logic [7:0] mem_rdata,
  output logic mem_ready
);
  logic [7:0] bytes [0:65535];
  logic [7:0] junk = 8'h5A;
  assign mem_rdata = mem_rd ? bytes[mem_addr] : junk;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn)
      mem_ready <= 1'b0;
    else begin
      mem_ready <= slow ? ~mem_ready : 1'b1;
      junk <= junk + 8'h3B;
      if (mem_wr && mem_ready)
        bytes[mem_addr] <= mem_wdata;
    end
  end
endmodule

// ===== bench/byte_load_group_decoder_assertions.sv
// Port assertions for the byte load group decoder
`timescale 1ns/100ps
module byte_load_group_decoder_assertions (
  // Clock, reset and bus
  input wire logic mclk, rstn, mem_rd, mem_wr, mem_ready,
  input wire logic [15:0] mem_addr, pc,
  // Status
  input wire logic opcode_fetch_cycle, instr_done,
  input wire logic [2:0] instr_len,
  input wire logic [15:0] first_index_register, second_index_register
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_write_no_read: assert property (mem_wr |-> !mem_rd)
    else $error("read in write");
  a_write_holds: assert property (mem_wr && !mem_ready |=> mem_wr)
    else $error("write dropped");
  a_fetch_reads: assert property (opcode_fetch_cycle |-> mem_rd)
    else $error("fetch no read");
  a_fetch_steps: assert property (opcode_fetch_cycle && mem_ready
    |=> pc == $past(mem_addr) + 16'h0001) else $error("pc not stepped");
  a_stall_holds: assert property (!mem_ready |=> $stable(mem_addr))
    else $error("address moved");
  a_done_taken: assert property (instr_done |-> $past(mem_ready))
    else $error("done no step");
  a_len_ok: assert property (instr_done |-> instr_len inside {[1:4]})
    else $error("bad length");
  a_index_fixed: assert property ($stable(first_index_register)
    && $stable(second_index_register)) else $error("index moved");
  c_write: cover property (mem_wr && mem_ready);
  c_four: cover property (instr_done && instr_len == 3'h4);
  c_stall: cover property (opcode_fetch_cycle && !mem_ready);
endmodule
bind byte_load_group_decoder byte_load_group_decoder_assertions chk (.mclk,
  .rstn, .mem_rd, .mem_wr, .mem_ready, .mem_addr, .pc, .opcode_fetch_cycle,
  .instr_done, .instr_len, .first_index_register, .second_index_register);

// ===== bench/byte_load_group_decoder_tb.sv
// Testbench for the byte load group decoder
`timescale 1ns/100ps
module byte_load_group_decoder_tb;
  logic mclk = 1'b0, rstn = 1'b0, slow = 1'b0;
  logic mem_rd, mem_wr, mem_ready, opcode_fetch_cycle, instr_done;
  logic [15:0] mem_addr, first_index_register, second_index_register, pc;
  logic [7:0] mem_wdata, mem_rdata;
  logic [2:0] instr_len;
  logic [63:0] reg_view;
  int num_errors = 0, n_compared = 0;
  logic [207:0] prog = {104'h065A4826362E1016A5723A326F,
    104'hDD5EF0FD6E08DD36FE99323412};
  logic [43:0] lens = 44'h21222133343;
  always #5 mclk = ~mclk;
  byte_load_group_decoder DUT (.mclk, .rstn, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .mem_ready, .opcode_fetch_cycle, .instr_done,
    .instr_len, .reg_view, .first_index_register, .second_index_register, .pc);
  program_memory mem (.mclk, .rstn, .slow, .mem_addr, .mem_rd, .mem_wr,
    .mem_wdata, .mem_rdata, .mem_ready);
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run_program(logic stall);
    int k;
    @(posedge mclk);
    rstn <= 1'b0;
    slow <= stall;
    for (k = 0; k < 65536; k++)
      mem.bytes[k] = (k < 26) ? prog[207 - 8 * k -: 8] : 8'h00;
    mem.bytes[16'hFFF0] = 8'h7E;
    mem.bytes[16'h6F32] = 8'hC3;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    for (k = 0; k < 11; k++) begin
      @(negedge mclk);
      repeat (99) if (instr_done !== 1'b1) @(negedge mclk);
      check("done", 1'b1, instr_done);
      check("len", lens[43 - 4 * k -: 4], instr_len);
    end
    check("pc", 16'h001A, pc);
    check("index", 32'h0, {first_index_register,
      second_index_register});
    check("acc", 8'hC3, reg_view[63:56]);
    check("regs", 48'hA5367EA55A5A, reg_view[47:0]);
    check("stores", 24'hA599C3, {mem.bytes[16'h3610],
      mem.bytes[16'hFFFE], mem.bytes[16'h1234]});
    $display("test with stall %0b ended", stall);
  endtask
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    run_program(1'b0);
    run_program(1'b1);
    report_and_stop();
  end
endmodule
